/* File: shared/fifo_rt_pkg.sv */
package fifo_rt_pkg;

  // ************************************************************
  // widths and counts
  // ************************************************************
  localparam int DATA_W   = 36;
  localparam int OFF_W    = 19;
  localparam int OFF_LO_W = 18;
  localparam int OFF_HI_W = OFF_W - OFF_LO_W;
  localparam int MARK_GAP = 128;

  // ************************************************************
  // programming sequence positions
  // ************************************************************
  localparam logic [1:0] PROG_EMPTY_LO = 2'h0;
  localparam logic [1:0] PROG_EMPTY_HI = 2'h1;
  localparam logic [1:0] PROG_FULL_LO  = 2'h2;
  localparam logic [1:0] PROG_FULL_HI  = 2'h3;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [OFF_W-1:0] EMPTY_OFF_RST = 19'h0007f;
  localparam logic [OFF_W-1:0] FULL_OFF_RST  = 19'h0007f;

  // ************************************************************
  // controller states
  // ************************************************************
  typedef enum logic [1:0] {
    C_IDLE    = 2'b00,
    C_PROG    = 2'b01,
    C_RT_GAP  = 2'b10,
    C_RT_HOLD = 2'b11
  } ctl_state_t;

endpackage

/* File: shared/fifo_link_if.sv */
`timescale 1ns/100ps
interface fifo_link_if;
  import fifo_rt_pkg::*;

  logic              offset_load_n;
  logic              write_enable_n;
  logic [DATA_W-1:0] write_data_bus;
  logic              read_enable_n;
  logic              mark;
  logic              retransmit_n;
  logic [DATA_W-1:0] read_data_bus;
  logic              empty_flag_n;
  logic              output_ready_n;
  logic              full_flag_n;
  logic              almost_empty_flag_n;
  logic              almost_full_flag_n;
  logic              first_word_fall_through_mode;

  modport dev (
    input  offset_load_n, write_enable_n, write_data_bus, read_enable_n, mark,
    input  retransmit_n,
    output read_data_bus, empty_flag_n, output_ready_n, full_flag_n,
    output almost_empty_flag_n, almost_full_flag_n, first_word_fall_through_mode
  );

  modport ctl (
    output offset_load_n, write_enable_n, write_data_bus, read_enable_n, mark,
    output retransmit_n,
    input  read_data_bus, empty_flag_n, output_ready_n, full_flag_n,
    input  almost_empty_flag_n, almost_full_flag_n, first_word_fall_through_mode
  );

endinterface

/* File: rtl/fifo_rt_ctl.sv */
`timescale 1ns/100ps
module fifo_rt_ctl
  import fifo_rt_pkg::*;
#(
  parameter int DEPTH = 512
)
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  fifo_link_if.ctl                link,
  input  wire logic               prog_req,
  input  wire logic [OFF_W-1:0]   prog_empty_off,
  input  wire logic [OFF_W-1:0]   prog_full_off,
  output logic                    prog_busy,
  input  wire logic               wr_req,
  input  wire logic [DATA_W-1:0]  wr_data,
  output logic                    wr_taken,
  input  wire logic               rd_req,
  output logic                    rd_valid,
  output logic [DATA_W-1:0]       rd_data,
  input  wire logic               mark_req,
  input  wire logic               retx_req,
  output logic                    mark_active
);

  localparam int LW = $clog2(DEPTH) + 1;

  ctl_state_t        state_r;
  logic [1:0]        prog_cnt_r;
  logic              ld_n_r;
  logic              wen_n_r;
  logic [DATA_W-1:0] wdata_r;
  logic              ren_n_r;
  logic              mark_r;
  logic              rt_n_r;
  logic              acc_r;
  logic [LW-1:0]     level_r;
  logic [LW-1:0]     since_mark_r;
  logic              wr_acc;
  logic              std_acc;
  logic              ff_acc;
  logic              gap_ok;

  assign link.offset_load_n  = ld_n_r;
  assign link.write_enable_n = wen_n_r;
  assign link.write_data_bus = wdata_r;
  assign link.read_enable_n  = ren_n_r;
  assign link.mark           = mark_r;
  assign link.retransmit_n   = rt_n_r;

  // accepted transfers as seen on this edge
  assign wr_acc  = !wen_n_r && ld_n_r && link.full_flag_n;
  assign std_acc = !link.first_word_fall_through_mode && !ren_n_r && link.empty_flag_n;
  assign ff_acc  = link.first_word_fall_through_mode && !ren_n_r && !link.output_ready_n;
  assign gap_ok  = level_r <= LW'(DEPTH - MARK_GAP); // no wrap when the count runs high

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r    <= C_IDLE;
      prog_cnt_r <= PROG_EMPTY_LO;
      ld_n_r     <= 1'b1;
      wen_n_r    <= 1'b1;
      wdata_r    <= 36'h0;
      ren_n_r    <= 1'b1;
      rt_n_r     <= 1'b1;
    end
    else
    begin
      ld_n_r  <= 1'b1;
      wen_n_r <= 1'b1;
      ren_n_r <= 1'b1;
      rt_n_r  <= 1'b1;
      case (state_r)
        C_IDLE:
        begin
          if (prog_req)
          begin
            state_r    <= C_PROG;
            prog_cnt_r <= PROG_EMPTY_LO;
          end
          else if (retx_req && mark_r)
            state_r <= C_RT_GAP;
          else
          begin
            wen_n_r <= !wr_req;
            wdata_r <= wr_data;
            ren_n_r <= !rd_req;
          end
        end
        C_PROG:
        begin
          ld_n_r     <= 1'b0;
          wen_n_r    <= 1'b0;
          prog_cnt_r <= prog_cnt_r + 2'h1;
          case (prog_cnt_r)
            PROG_EMPTY_LO: wdata_r <= DATA_W'(prog_empty_off[OFF_LO_W-1:0]);
            PROG_EMPTY_HI: wdata_r <= DATA_W'(prog_empty_off[OFF_W-1:OFF_LO_W]);
            PROG_FULL_LO:  wdata_r <= DATA_W'(prog_full_off[OFF_LO_W-1:0]);
            default:       wdata_r <= DATA_W'(prog_full_off[OFF_W-1:OFF_LO_W]);
          endcase
          if (prog_cnt_r == PROG_FULL_HI)
            state_r <= C_IDLE;
        end
        C_RT_GAP:
          state_r <= C_RT_HOLD;
        C_RT_HOLD:
        begin
          rt_n_r <= 1'b0;
          if (!retx_req)
            state_r <= C_IDLE;
        end
        default:
          state_r <= C_IDLE;
      endcase
    end
  end

  // ************************************************************
  // mark with gap check, word accounting
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mark_r       <= 1'b0;
      level_r      <= '0;
      since_mark_r <= '0;
    end
    else
    begin
      mark_r <= mark_req && (mark_r || gap_ok);
      if (!mark_r)
        since_mark_r <= LW'(1);
      else if (std_acc || ff_acc)
        since_mark_r <= since_mark_r + LW'(1);
      if (!rt_n_r && mark_r)
        level_r <= level_r + since_mark_r;
      else
        level_r <= level_r + LW'(wr_acc) - LW'(std_acc || ff_acc);
      if (!rt_n_r && mark_r)
        since_mark_r <= LW'(1);
    end
  end

  // ************************************************************
  // user answers
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_r       <= 1'b0;
      rd_valid    <= 1'b0;
      rd_data     <= 36'h0;
      wr_taken    <= 1'b0;
      prog_busy   <= 1'b0;
      mark_active <= 1'b0;
    end
    else
    begin
      acc_r       <= std_acc;
      rd_valid    <= acc_r || ff_acc;
      if (acc_r || ff_acc)
        rd_data <= link.read_data_bus;
      wr_taken    <= wr_acc;
      prog_busy   <= (state_r == C_IDLE) ? prog_req : (state_r == C_PROG);
      mark_active <= mark_r;
    end
  end

endmodule

/* File: rtl/fifo_rt_device.sv */
`timescale 1ns/100ps
module fifo_rt_device
  import fifo_rt_pkg::*;
#(
  parameter int DEPTH = 512
)
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               first_word_fall_through_strap,
  input  wire logic               parallel_strap,
  fifo_link_if.dev                link,
  output logic [OFF_W-1:0]        empty_offset,
  output logic [OFF_W-1:0]        full_offset,
  output logic                    retransmit_mode
);

  localparam int AW = $clog2(DEPTH);

  logic [DATA_W-1:0] mem_r [DEPTH];
  logic              first_word_fall_through_r;
  logic              par_r;
  logic [1:0]        strap_s1_r;
  logic [1:0]        strap_s2_r;
  logic [1:0]        prog_cnt_r;
  logic [AW:0]       wr_ptr_r;
  logic [AW:0]       wr_ptr_nxt;
  logic [AW:0]       rd_ptr_r;
  logic [AW:0]       rd_ptr_nxt;
  logic [AW:0]       mark_ptr_r;
  logic [AW:0]       mark_ptr_nxt;
  logic              mark_mode_nxt;
  logic [AW:0]       level;
  logic [AW:0]       level_nxt;
  logic [DATA_W-1:0] dout_r;
  logic              ef_n_r;
  logic              or_n_r;
  logic              ff_n_r;
  logic              ae_n_r;
  logic              af_n_r;
  logic              prog_we;
  logic              mem_we;
  logic              mark_enter;
  logic              rt_hit;
  logic              std_rd;
  logic              ff_load;
  logic              ff_drop;
  logic              wr_blocked;

  // ************************************************************
  // helpers
  // ************************************************************

  // level at or below a programmed offset
  function automatic logic at_most(input logic [AW:0] lvl, input logic [OFF_W-1:0] off);
    at_most = ({{OFF_W{1'b0}}, lvl} <= {{(AW+1){1'b0}}, off});
  endfunction

  assign link.read_data_bus       = dout_r;
  assign link.empty_flag_n        = ef_n_r;
  assign link.output_ready_n      = or_n_r;
  assign link.full_flag_n         = ff_n_r;
  assign link.almost_empty_flag_n = ae_n_r;
  assign link.almost_full_flag_n  = af_n_r;
  assign link.first_word_fall_through_mode           = first_word_fall_through_r;

  // ************************************************************
  // strap capture during reset
  // ************************************************************

  // strap pins pass two flops before anything reads them
  always_ff @(posedge clk)
  begin
    strap_s1_r <= {parallel_strap, first_word_fall_through_strap};
    strap_s2_r <= strap_s1_r;
  end

  // mode and programming method only sampled while reset is low
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      first_word_fall_through_r <= strap_s2_r[0];
      par_r  <= strap_s2_r[1];
    end
  end

  // ************************************************************
  // parallel offset programming
  // ************************************************************
  assign prog_we = par_r && !link.offset_load_n && !link.write_enable_n;

  // sequence position restarts whenever load is released
  always_ff @(posedge clk)
  begin
    if (!rst_n || link.offset_load_n)
      prog_cnt_r <= PROG_EMPTY_LO;
    else if (prog_we)
      prog_cnt_r <= prog_cnt_r + 2'h1;
  end

  // offset registers, low part first then high part
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      empty_offset <= EMPTY_OFF_RST;
      full_offset  <= FULL_OFF_RST;
    end
    else if (prog_we)
    begin
      case (prog_cnt_r)
        PROG_EMPTY_LO: empty_offset[OFF_LO_W-1:0]     <= link.write_data_bus[OFF_LO_W-1:0];
        PROG_EMPTY_HI: empty_offset[OFF_W-1:OFF_LO_W] <= link.write_data_bus[OFF_HI_W-1:0];
        PROG_FULL_LO:  full_offset[OFF_LO_W-1:0]      <= link.write_data_bus[OFF_LO_W-1:0];
        default:       full_offset[OFF_W-1:OFF_LO_W]  <= link.write_data_bus[OFF_HI_W-1:0];
      endcase
    end
  end

  // ************************************************************
  // mark and retransmit decode
  // ************************************************************
  assign level = wr_ptr_r - rd_ptr_r;

  // entry needs readable data shown per mode
  assign mark_enter = !retransmit_mode && link.mark &&
                      (first_word_fall_through_r ? !or_n_r : ef_n_r);

  // rewind whenever retransmit is low with mark high in retransmit mode
  assign rt_hit = retransmit_mode && link.mark && !link.retransmit_n;

  // standard read: enabled, flag high, not in setup
  assign std_rd = !first_word_fall_through_r && !link.read_enable_n && ef_n_r && !rt_hit &&
                  (level != '0);

  // fall-through: refill an empty output or advance on read enable
  assign ff_load = first_word_fall_through_r && !rt_hit && (level != '0) &&
                   (or_n_r || !link.read_enable_n);
  assign ff_drop = first_word_fall_through_r && !rt_hit && (level == '0) &&
                   !or_n_r && !link.read_enable_n;

  // the marked slot is never overwritten
  assign wr_blocked = !ff_n_r;
  assign mem_we     = link.offset_load_n && !link.write_enable_n && !wr_blocked;

  // ************************************************************
  // next pointer values
  // ************************************************************
  always_comb
  begin
    wr_ptr_nxt    = wr_ptr_r;
    rd_ptr_nxt    = rd_ptr_r;
    mark_ptr_nxt  = mark_ptr_r;
    mark_mode_nxt = retransmit_mode;
    if (mem_we)
      wr_ptr_nxt = wr_ptr_r + (AW+1)'(1);
    if (rt_hit)
      rd_ptr_nxt = mark_ptr_r;
    else if (std_rd || ff_load)
      rd_ptr_nxt = rd_ptr_r + (AW+1)'(1);
    if (!link.mark)
      mark_mode_nxt = 1'b0;
    else if (mark_enter)
    begin
      mark_mode_nxt = 1'b1;
      mark_ptr_nxt  = rd_ptr_r - (AW+1)'(1);
    end
  end

  assign level_nxt = wr_ptr_nxt - rd_ptr_nxt;

  // ************************************************************
  // pointers and mode
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_r        <= '0;
      rd_ptr_r        <= '0;
      mark_ptr_r      <= '0;
      retransmit_mode <= 1'b0;
    end
    else
    begin
      wr_ptr_r        <= wr_ptr_nxt;
      rd_ptr_r        <= rd_ptr_nxt;
      mark_ptr_r      <= mark_ptr_nxt;
      retransmit_mode <= mark_mode_nxt;
    end
  end

  // ************************************************************
  // storage
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem_r[wr_ptr_r[AW-1:0]] <= link.write_data_bus;
  end

  // output register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dout_r <= 36'h0;
    else if (std_rd || ff_load)
      dout_r <= mem_r[rd_ptr_r[AW-1:0]];
  end

  // ************************************************************
  // status flags
  // ************************************************************

  // empty flag held low through retransmit setup
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ef_n_r <= 1'b0;
    else
      ef_n_r <= !first_word_fall_through_r && !rt_hit && (level_nxt != '0);
  end

  // output ready high during setup, low once a word is loaded
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      or_n_r <= 1'b1;
    else if (rt_hit)
      or_n_r <= 1'b1;
    else if (ff_load)
      or_n_r <= 1'b0;
    else if (ff_drop || !first_word_fall_through_r)
      or_n_r <= 1'b1;
  end

  // full flag also stops the write pointer at the mark
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ff_n_r <= 1'b1;
    else
      ff_n_r <= !((level_nxt == (AW+1)'(DEPTH)) ||
                  (mark_mode_nxt &&
                   (wr_ptr_nxt[AW-1:0] == mark_ptr_nxt[AW-1:0])));
  end

  // programmable threshold flags
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ae_n_r <= 1'b0;
      af_n_r <= 1'b1;
    end
    else
    begin
      ae_n_r <= !at_most(level_nxt, empty_offset);
      af_n_r <= !at_most((AW+1)'(DEPTH) - level_nxt, full_offset);
    end
  end

endmodule

/* File: dv/fifo_link_properties.sv */
`timescale 1ns/100ps
module fifo_link_properties
  import fifo_rt_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              offset_load_n,
  input wire logic              write_enable_n,
  input wire logic              read_enable_n,
  input wire logic              mark,
  input wire logic              retransmit_n,
  input wire logic [DATA_W-1:0] read_data_bus,
  input wire logic              empty_flag_n,
  input wire logic              output_ready_n,
  input wire logic              first_word_fall_through_mode
);
  // ************************************************************
  // link relations
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_prog_both_low: assert property (!offset_load_n |-> !write_enable_n)
    else $error("offset load without write enable");
  a_prog_four_edges: assert property ($fell(offset_load_n) |-> !offset_load_n [*4] ##1 offset_load_n)
    else $error("programming not four writes");
  a_rt_reads_off: assert property (!retransmit_n |-> read_enable_n && $past(read_enable_n))
    else $error("read enabled around retransmit");
  a_std_empty_low: assert property (!first_word_fall_through_mode && mark && !retransmit_n |=> !empty_flag_n)
    else $error("empty flag not low in setup");
  a_std_empty_rise: assert property (!first_word_fall_through_mode && mark && $rose(retransmit_n) |=> empty_flag_n)
    else $error("empty flag not high after setup");
  a_first_word_fall_through_ready_high: assert property (first_word_fall_through_mode && mark && !retransmit_n |=> output_ready_n)
    else $error("ready flag not high in setup");
  a_first_word_fall_through_ready_low: assert property (first_word_fall_through_mode && mark && $rose(retransmit_n) |=> !output_ready_n)
    else $error("ready flag not low after setup");
  a_std_read_gated: assert property (!first_word_fall_through_mode && $changed(read_data_bus) |-> !$past(read_enable_n))
    else $error("output word changed without read");
  a_first_word_fall_through_read_gated: assert property (first_word_fall_through_mode && $changed(read_data_bus)
    |-> !$past(read_enable_n) || $past(output_ready_n))
    else $error("output word changed without read or load");

  c_prog: cover property ($fell(offset_load_n));
  c_std_retx: cover property (!first_word_fall_through_mode && mark && $rose(retransmit_n));
  c_first_word_fall_through_retx: cover property (first_word_fall_through_mode && mark && $rose(retransmit_n));
endmodule

/* File: dv/fifo_retransmit_offset_load_tb_top.sv */
`timescale 1ns/100ps
module fifo_retransmit_offset_load_tb_top
  import fifo_rt_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              first_word_fall_through_strap = 1'b0;
  logic              parallel_strap = 1'b0;
  logic              prog_req = 1'b0;
  logic [OFF_W-1:0]  prog_empty_off = 19'h0;
  logic [OFF_W-1:0]  prog_full_off = 19'h0;
  logic              wr_req = 1'b0;
  logic [DATA_W-1:0] wr_data = 36'h0;
  logic              rd_req = 1'b0;
  logic              mark_req = 1'b0;
  logic              retx_req = 1'b0;
  logic              prog_busy, wr_taken, rd_valid, mark_active, retransmit_mode;
  logic [DATA_W-1:0] rd_data;
  logic [OFF_W-1:0]  empty_offset, full_offset;
  int                bad_count = 0;
  int                tests_run = 0;

  // ************************************************************
  // clock and the two ends
  // ************************************************************
  initial
  begin
    forever #5 clk = ~clk;
  end

  fifo_link_if fifo_link_if_inst ();
  fifo_rt_device #(.DEPTH(512)) fifo_rt_device_inst (.clk(clk), .rst_n(rst_n),
    .first_word_fall_through_strap(first_word_fall_through_strap), .parallel_strap(parallel_strap), .link(fifo_link_if_inst.dev),
    .empty_offset(empty_offset), .full_offset(full_offset), .retransmit_mode(retransmit_mode));
  fifo_rt_ctl #(.DEPTH(512)) fifo_rt_ctl_inst (.clk(clk), .rst_n(rst_n),
    .link(fifo_link_if_inst.ctl), .prog_req(prog_req), .prog_empty_off(prog_empty_off),
    .prog_full_off(prog_full_off), .prog_busy(prog_busy), .wr_req(wr_req), .wr_data(wr_data),
    .wr_taken(wr_taken), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
    .mark_req(mark_req), .retx_req(retx_req), .mark_active(mark_active));
  fifo_link_properties fifo_link_properties_inst (.clk(clk), .rst_n(rst_n),
    .offset_load_n(fifo_link_if_inst.offset_load_n),
    .write_enable_n(fifo_link_if_inst.write_enable_n),
    .read_enable_n(fifo_link_if_inst.read_enable_n), .mark(fifo_link_if_inst.mark),
    .retransmit_n(fifo_link_if_inst.retransmit_n),
    .read_data_bus(fifo_link_if_inst.read_data_bus),
    .empty_flag_n(fifo_link_if_inst.empty_flag_n),
    .output_ready_n(fifo_link_if_inst.output_ready_n), .first_word_fall_through_mode(fifo_link_if_inst.first_word_fall_through_mode));

  // ************************************************************
  // compares, bus tasks and verdict
  // ************************************************************
  task automatic flag_bad(input string msg);
    bad_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp)
      flag_bad($sformatf("word %h expected %h", got, exp));
  endtask

  task automatic chk_off(input logic [OFF_W-1:0] got, input logic [OFF_W-1:0] exp);
    tests_run++;
    if (got !== exp)
      flag_bad($sformatf("offset %h expected %h", got, exp));
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
      flag_bad($sformatf("flag %b expected %b", got, exp));
  endtask

  function automatic logic [DATA_W-1:0] word_of(input int i);
    return {12'hc5a, 24'(i)};
  endfunction

  // reset with straps set up; the straps stand at the release edge
  task automatic do_reset(input logic fw, input logic par);
    @(posedge clk);
    rst_n <= 1'b0;
    first_word_fall_through_strap <= fw;
    parallel_strap <= par;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic prog(input logic [OFF_W-1:0] e, input logic [OFF_W-1:0] f);
    @(posedge clk);
    prog_req <= 1'b1;
    prog_empty_off <= e;
    prog_full_off <= f;
    @(posedge clk);
    prog_req <= 1'b0;
    @(negedge clk);
    chk_bit(prog_busy, 1'b1);
    repeat (7) @(negedge clk);
    chk_bit(prog_busy, 1'b0);
  endtask

  // one write; ok tells whether the device took it
  task automatic write_word(input int i, output logic ok);
    ok = 1'b0;
    @(posedge clk);
    wr_req <= 1'b1;
    wr_data <= word_of(i);
    @(posedge clk);
    wr_req <= 1'b0;
    repeat (3)
    begin
      @(negedge clk);
      if (wr_taken === 1'b1)
        ok = 1'b1;
    end
  endtask

  task automatic read_chk(input int i);
    logic [DATA_W-1:0] d;
    d = {DATA_W{1'bx}};
    @(posedge clk);
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    repeat (5)
    begin
      @(negedge clk);
      if (rd_valid === 1'b1)
        d = rd_data;
    end
    chk_word(d, word_of(i));
  endtask

  task automatic set_mark(input logic v);
    @(posedge clk);
    mark_req <= v;
    repeat (4) @(negedge clk);
  endtask

  // hold keeps the request up for that many edges; retransmit then goes low for hold-1 edges, at least one
  task automatic retx(input int hold);
    @(posedge clk);
    retx_req <= 1'b1;
    repeat (hold) @(posedge clk);
    retx_req <= 1'b0;
    repeat (6) @(negedge clk);
  endtask

  task automatic fill(input int n);
    logic ok;
    for (int i = 0; i < n; i++)
      write_word(i, ok);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic prog_scenario();
    do_reset(1'b0, 1'b0);
    parallel_strap <= 1'b1;
    prog(19'h4a5a5, 19'h7c3c1);
    chk_off(empty_offset, EMPTY_OFF_RST);
    chk_off(full_offset, FULL_OFF_RST);
    do_reset(1'b0, 1'b1);
    prog(19'h4a5a5, 19'h7c3c1);
    chk_off(empty_offset, 19'h4a5a5);
    chk_off(full_offset, 19'h7c3c1);
  endtask

  task automatic std_scenario();
    logic              ok;
    logic [DATA_W-1:0] n;
    n = 36'h0;
    do_reset(1'b0, 1'b1);
    @(negedge clk);
    chk_bit(fifo_link_if_inst.empty_flag_n, 1'b0);
    // mark on an empty fifo must not enter retransmit mode
    set_mark(1'b1);
    chk_bit(mark_active, 1'b1);
    chk_bit(retransmit_mode, 1'b0);
    set_mark(1'b0);
    fill(140);
    for (int i = 0; i < 3; i++)
      read_chk(i);
    set_mark(1'b1);
    chk_bit(retransmit_mode, 1'b1);
    read_chk(3);
    read_chk(4);
    repeat (2)
    begin
      retx(1);
      read_chk(2);
      read_chk(3);
    end
    set_mark(1'b0);
    chk_bit(retransmit_mode, 1'b0);
    set_mark(1'b1);
    read_chk(4);
    retx(1);
    read_chk(3);
    // marked slot 3 blocks the write pointer after slots 140..511 and 0..2
    for (int i = 140; i < 540; i++)
    begin
      write_word(i, ok);
      if (ok === 1'b1)
        n++;
    end
    chk_word(n, 36'h177);
    retx(1);
    read_chk(3);
    set_mark(1'b0);
  endtask

  task automatic first_word_fall_through_scenario();
    do_reset(1'b1, 1'b1);
    @(negedge clk);
    chk_bit(fifo_link_if_inst.output_ready_n, 1'b1);
    set_mark(1'b1);
    chk_bit(retransmit_mode, 1'b0);
    set_mark(1'b0);
    fill(140);
    for (int i = 0; i < 3; i++)
      read_chk(i);
    set_mark(1'b1);
    chk_bit(retransmit_mode, 1'b1);
    read_chk(3);
    read_chk(4);
    retx(3);
    chk_word(fifo_link_if_inst.read_data_bus, word_of(3));
    chk_bit(fifo_link_if_inst.output_ready_n, 1'b0);
    read_chk(3);
    read_chk(4);
    set_mark(1'b0);
  endtask

  initial
  begin
    prog_scenario();
    std_scenario();
    first_word_fall_through_scenario();
    final_report();
  end

  // hang guard, well beyond the expected few thousand cycles
  initial
  begin
    #400000;
    flag_bad("watchdog ran out");
    final_report();
  end
endmodule
